// ---- design/rip_top.sv ----
// Reset and interrupt prioritiser: arbitration, options, promotion and keyboard status.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Behaviour
// - Three reset vectors, eighteen interrupt vectors, separate.
// - Thirty sources: three non-maskable, twenty-seven maskable.
// - Maskable requests only while global mask clear.
// - Promotion register written only while mask set.
// - Every maskable source has its own enable, except overrun, which shares the receive enable.
// - Keyboard lines share the pin request vector.
// - Reading keyboard status clears its pending flags.
// - Reset vectors FFFE, FFFC, FFFA with gating.
// - Nonmaskable pin FFF4, software FFF6, illegal FFF8.
// - Software and illegal traps bypass arbitration.
// - All serial communications interface sources share FFD6.
// - Serial peripheral done uses FFD8, priority 20.
// - Accumulator edge, overflow, timer overflow vectors.
// - Timer channels FFE0 to FFEE, periodic FFF0.
// - Protected option bits written once early.
// - Pin request low level or falling edge.
// - Stop exit delay follows the delay bit.
// - Clock monitor enable forces clock-failure reset.
// - Four-bit select promotes one source; 0101 means pin.
// - Status bit 7 pin, bits 6-0 lines, read-only.
// - Watchdog rate selects 2^15 to 2^21 E.
//----------------------------------------------------------------------
module rip_top import rip_pkg::*; #(
  parameter int WDOG_BASE_LOG2 = 15,
  parameter int E_DIV = 4,
  parameter int STOP_DELAY_CYC = 16
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic i_mask_i,
  input wire logic x_mask_i,
  input wire logic special_mode_i,
  input wire logic watchdog_disable_i,
  input wire logic irq_pin_n_i,
  input wire logic nonmaskable_pin_request_pin_n_i,
  input wire logic [6:0] kbd_line_n_i,
  input wire logic clock_slow_i,
  input wire logic sci_rx_full_i,
  input wire logic sci_overrun_i,
  input wire logic sci_tx_empty_i,
  input wire logic sci_tx_done_i,
  input wire logic sci_idle_i,
  input wire logic spi_done_i,
  input wire logic acc_edge_i,
  input wire logic acc_ovf_i,
  input wire logic timer_ovf_i,
  input wire logic [7:0] timer_chan_i,
  input wire logic rti_i,
  input wire logic handshake_i,
  input wire logic swi_i,
  input wire logic illegal_i,
  input wire logic wdog_service_i,
  input wire logic stop_exit_i,
  output logic irq_req_o,
  output logic [15:0] irq_vec_o,
  output logic trap_vld_o,
  output logic [15:0] trap_vec_o,
  output logic reset_req_o,
  output logic [15:0] reset_vec_o,
  output logic clock_ready_o,
  output logic [7:0] options_o
);
  localparam int WDOG_W = WDOG_BASE_LOG2 + 2 * WDOG_LOG2_STEP * 2 - 1;
  localparam int EW = $clog2(E_DIV) + 1;
  localparam int SW = $clog2(STOP_DELAY_CYC) + 1;

  //--------------------------------------------------------------------
  // Pin synchronisers
  //--------------------------------------------------------------------
  logic [9:0] pins_s;
  logic irq_s;
  logic nonmaskable_pin_request_s;
  logic [6:0] kbd_s;
  logic slow_s;

  rip_sync #(.W(10), .RST_VAL(10'h1ff)) u_sync (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .async_i({clock_slow_i, nonmaskable_pin_request_pin_n_i, irq_pin_n_i, kbd_line_n_i}),
    .sync_o(pins_s)
  );
  assign {slow_s, nonmaskable_pin_request_s, irq_s, kbd_s} = pins_s;

  //--------------------------------------------------------------------
  // Register file
  //--------------------------------------------------------------------
  logic [7:0] opt_q;
  logic [6:0] kbd_en_q;
  logic [7:0] kbd_stat_q;
  logic [7:0] en_ser_q;
  logic [7:0] en_tmr_q;
  logic [2:0] en_misc_q;
  logic [3:0] promote_q;
  logic [6:0] win_cnt_q;
  logic once_done_q;
  logic irq_prev_q;
  logic prot_open;
  logic rd_stat;
  logic irq_fall;
  logic [7:0] kbd_set;

  assign prot_open = special_mode_i || (!once_done_q && win_cnt_q < PROT_WINDOW);
  assign rd_stat = rd_i && addr_i == ADDR_KBD_STAT;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      win_cnt_q <= 7'h00;
    end else if (win_cnt_q < PROT_WINDOW) begin
      win_cnt_q <= win_cnt_q + 7'h01;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      opt_q <= OPTIONS_RST;
      once_done_q <= 1'b0;
    end else if (wr_i && addr_i == ADDR_OPTIONS) begin
      if (prot_open) begin
        opt_q <= wdata_i & (OPT_MASK_ANY | OPT_MASK_ONCE);
        once_done_q <= !special_mode_i;
      end else begin
        opt_q <= (wdata_i & OPT_MASK_ANY) | (opt_q & OPT_MASK_ONCE);
      end
    end
  end

  // Promotion is locked while interrupts are live so the order cannot shift under a pending request.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      promote_q <= PROMOTE_RST;
    end else if (wr_i && addr_i == ADDR_PROMOTE && i_mask_i) begin
      promote_q <= wdata_i[3:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      kbd_en_q <= 7'h00;
      en_ser_q <= 8'h00;
      en_tmr_q <= 8'h00;
      en_misc_q <= 3'h0;
    end else if (wr_i) begin
      if (addr_i == ADDR_KBD_EN) begin
        kbd_en_q <= wdata_i[6:0];
      end else if (addr_i == ADDR_EN_SERIAL) begin
        en_ser_q <= wdata_i;
      end else if (addr_i == ADDR_EN_TIMER) begin
        en_tmr_q <= wdata_i;
      end else if (addr_i == ADDR_EN_MISC) begin
        en_misc_q <= wdata_i[2:0];
      end
    end
  end

  //--------------------------------------------------------------------
  // Keyboard and pin request status
  //--------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_prev_q <= 1'b1;
    end else begin
      irq_prev_q <= irq_s;
    end
  end

  assign irq_fall = irq_prev_q && !irq_s;

  always_comb begin
    kbd_set[6:0] = kbd_en_q & ~kbd_s;
    kbd_set[KBD_PIN_BIT] = en_misc_q[EN_IRQ] && (opt_q[OPT_EDGE] ? irq_fall : !irq_s);
  end

  // A request arriving during the clearing read is kept, so no edge is lost.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      kbd_stat_q <= 8'h00;
    end else begin
      kbd_stat_q <= (rd_stat ? 8'h00 : kbd_stat_q) | kbd_set;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 8'h00;
    end else if (!rd_i) begin
      rdata_o <= 8'h00;
    end else if (addr_i == ADDR_KBD_EN) begin
      rdata_o <= {1'b0, kbd_en_q};
    end else if (addr_i == ADDR_OPTIONS) begin
      rdata_o <= opt_q;
    end else if (addr_i == ADDR_KBD_STAT) begin
      rdata_o <= kbd_stat_q;
    end else if (addr_i == ADDR_EN_SERIAL) begin
      rdata_o <= en_ser_q;
    end else if (addr_i == ADDR_EN_TIMER) begin
      rdata_o <= en_tmr_q;
    end else if (addr_i == ADDR_PROMOTE) begin
      rdata_o <= {4'h0, promote_q};
    end else if (addr_i == ADDR_EN_MISC) begin
      rdata_o <= {5'h00, en_misc_q};
    end else begin
      rdata_o <= 8'h00;
    end
  end

  //--------------------------------------------------------------------
  // Arbitration
  //--------------------------------------------------------------------
  logic [NUM_GROUPS-1:0] grp_pend;
  logic [3:0] prom_grp;
  logic [3:0] win_grp;
  logic mask_any;
  logic nonmaskable_pin_request_act;
  logic pin_req;

  assign pin_req = opt_q[OPT_EDGE] ? kbd_stat_q[KBD_PIN_BIT] : (en_misc_q[EN_IRQ] && !irq_s);
  assign nonmaskable_pin_request_act = !x_mask_i && !nonmaskable_pin_request_s;
  assign prom_grp = psel_to_group(promote_q);

  always_comb begin
    grp_pend = '0;
    grp_pend[GRP_IRQ] = pin_req || (|kbd_stat_q[6:0]) || (en_misc_q[EN_HS] && handshake_i);
    grp_pend[GRP_RTI] = en_misc_q[EN_RTI] && rti_i;
    for (int i = 0; i < 8; i++) begin
      grp_pend[int'(GRP_IC1) + i] = en_tmr_q[i] && timer_chan_i[i];
    end
    grp_pend[GRP_TOF] = en_ser_q[EN_TOF] && timer_ovf_i;
    grp_pend[GRP_ACCO] = en_ser_q[EN_ACCO] && acc_ovf_i;
    grp_pend[GRP_ACCE] = en_ser_q[EN_ACCE] && acc_edge_i;
    grp_pend[GRP_SPI] = en_ser_q[EN_SPI] && spi_done_i;
    grp_pend[GRP_SCI] = (en_ser_q[EN_RX] && (sci_rx_full_i || sci_overrun_i))
      || (en_ser_q[EN_TXE] && sci_tx_empty_i) || (en_ser_q[EN_TXC] && sci_tx_done_i)
      || (en_ser_q[EN_IDLE] && sci_idle_i);
  end

  always_comb begin
    win_grp = GRP_IRQ;
    mask_any = |grp_pend;
    for (int g = NUM_GROUPS - 1; g >= 0; g--) begin
      if (grp_pend[g]) begin
        win_grp = 4'(g);
      end
    end
    if (grp_pend[prom_grp]) begin
      win_grp = prom_grp;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_req_o <= 1'b0;
      irq_vec_o <= 16'h0000;
    end else if (nonmaskable_pin_request_act) begin
      irq_req_o <= 1'b1;
      irq_vec_o <= VEC_NONMASKABLE_PIN_REQUEST;
    end else if (mask_any && !i_mask_i) begin
      irq_req_o <= 1'b1;
      irq_vec_o <= group_vector(win_grp);
    end else begin
      irq_req_o <= 1'b0;
      irq_vec_o <= 16'h0000;
    end
  end

  // Instruction traps are decoded in the core, so they never wait on pending requests.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trap_vld_o <= 1'b0;
      trap_vec_o <= 16'h0000;
    end else begin
      trap_vld_o <= swi_i || illegal_i;
      trap_vec_o <= swi_i ? VEC_SWI : (illegal_i ? VEC_ILLEGAL : 16'h0000);
    end
  end

  //--------------------------------------------------------------------
  // Watchdog, clock monitor and reset cause
  //--------------------------------------------------------------------
  logic [EW-1:0] e_cnt_q;
  logic e_tick_q;
  logic [WDOG_W-1:0] wdog_cnt_q;
  logic wdog_to;
  logic clk_fail;

  function automatic logic [WDOG_W-1:0] wdog_limit(input logic [1:0] cr);
    wdog_limit = WDOG_W'(1) << (WDOG_BASE_LOG2 + WDOG_LOG2_STEP * int'(cr));
  endfunction

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      e_cnt_q <= '0;
      e_tick_q <= 1'b0;
    end else begin
      e_tick_q <= e_cnt_q == EW'(E_DIV - 1);
      e_cnt_q <= (e_cnt_q == EW'(E_DIV - 1)) ? '0 : e_cnt_q + EW'(1);
    end
  end

  assign wdog_to = !watchdog_disable_i && e_tick_q
    && wdog_cnt_q == wdog_limit(opt_q[OPT_CR_LO+:2]) - WDOG_W'(1);
  assign clk_fail = opt_q[OPT_CME] && slow_s;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wdog_cnt_q <= '0;
    end else if (watchdog_disable_i || wdog_service_i || wdog_to) begin
      wdog_cnt_q <= '0;
    end else if (e_tick_q) begin
      wdog_cnt_q <= wdog_cnt_q + WDOG_W'(1);
    end
  end

  // A clock-failure cause is held, and replaces a watchdog cause, until the system reset reloads the pin vector.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reset_req_o <= 1'b0;
      reset_vec_o <= VEC_RESET;
    end else if (clk_fail) begin
      reset_req_o <= 1'b1;
      reset_vec_o <= VEC_CLKFAIL;
    end else if (wdog_to && !reset_req_o) begin
      reset_req_o <= 1'b1;
      reset_vec_o <= VEC_WDOG;
    end
  end

  //--------------------------------------------------------------------
  // Stop exit delay
  //--------------------------------------------------------------------
  logic [SW-1:0] stop_cnt_q;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stop_cnt_q <= '0;
      clock_ready_o <= 1'b1;
    end else if (stop_exit_i && opt_q[OPT_DLY]) begin
      stop_cnt_q <= SW'(STOP_DELAY_CYC);
      clock_ready_o <= 1'b0;
    end else if (stop_cnt_q != '0) begin
      stop_cnt_q <= stop_cnt_q - SW'(1);
      clock_ready_o <= stop_cnt_q == SW'(1);
    end
  end

  assign options_o = opt_q;

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  sequence s_delay_exit;
    stop_exit_i && opt_q[OPT_DLY] && clock_ready_o;
  endsequence

  sequence s_held_low;
    !clock_ready_o ##1 !clock_ready_o;
  endsequence

  property p_mask_gate;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (irq_req_o && irq_vec_o != VEC_NONMASKABLE_PIN_REQUEST) |-> !$past(i_mask_i);
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("maskable request with mask set");

  property p_nonmaskable_pin_request_top;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      nonmaskable_pin_request_act |=> irq_req_o && irq_vec_o == VEC_NONMASKABLE_PIN_REQUEST;
  endproperty
  a_nonmaskable_pin_request_top: assert property (p_nonmaskable_pin_request_top) else $error("nonmaskable request not on top");

  property p_promote_lock;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (wr_i && addr_i == ADDR_PROMOTE && !i_mask_i) |=> $stable(promote_q);
  endproperty
  a_promote_lock: assert property (p_promote_lock) else $error("promotion changed while unmasked");

  property p_stat_clear;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (rd_stat && kbd_set == 8'h00) |=> kbd_stat_q == 8'h00;
  endproperty
  a_stat_clear: assert property (p_stat_clear) else $error("status not cleared by read");

  property p_once;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (wr_i && addr_i == ADDR_OPTIONS && !prot_open) |=> $stable(opt_q & OPT_MASK_ONCE);
  endproperty
  a_once: assert property (p_once) else $error("protected option bits changed");

  property p_clk_fail;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      clk_fail |=> reset_req_o && reset_vec_o == VEC_CLKFAIL;
  endproperty
  a_clk_fail: assert property (p_clk_fail) else $error("clock failure reset missing");

  property p_wdog;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (wdog_to && !clk_fail && !reset_req_o) |=> reset_req_o && reset_vec_o == VEC_WDOG;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog reset missing");

  property p_stop_delay;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      s_delay_exit |=> s_held_low;
  endproperty
  a_stop_delay: assert property (p_stop_delay) else $error("stop exit delay skipped");

  property p_trap;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      swi_i |=> trap_vld_o && trap_vec_o == VEC_SWI;
  endproperty
  a_trap: assert property (p_trap) else $error("software trap vector wrong");

  property p_level;
    @(posedge sys_clk_i) disable iff (!arst_n_i)
      (!opt_q[OPT_EDGE] && en_misc_q[EN_IRQ] && !irq_s && !i_mask_i) |=> irq_req_o;
  endproperty
  a_level: assert property (p_level) else $error("low level pin not recognised");
endmodule

// ---- design/rip_pkg.sv ----
// Constants, register map and vector tables of the reset and interrupt prioritiser.
package rip_pkg;
  localparam logic [7:0] ADDR_KBD_EN = 8'h05;
  localparam logic [7:0] ADDR_KBD_STAT = 8'h06;
  localparam logic [7:0] ADDR_OPTIONS = 8'h39;
  localparam logic [7:0] ADDR_EN_SERIAL = 8'h3a;
  localparam logic [7:0] ADDR_EN_TIMER = 8'h3b;
  localparam logic [7:0] ADDR_PROMOTE = 8'h3c;
  localparam logic [7:0] ADDR_EN_MISC = 8'h3d;
  localparam logic [7:0] OPTIONS_RST = 8'h10;
  localparam logic [7:0] OPT_MASK_ANY = 8'hc8;
  localparam logic [7:0] OPT_MASK_ONCE = 8'h33;
  localparam int OPT_CONVERTER_POWER_UP = 7;
  localparam int OPT_CONVERTER_CLOCK_SELECT = 6;
  localparam int OPT_EDGE = 5;
  localparam int OPT_DLY = 4;
  localparam int OPT_CME = 3;
  localparam int OPT_CR_LO = 0;
  localparam logic [6:0] PROT_WINDOW = 7'h40;
  localparam logic [3:0] PROMOTE_RST = 4'h6;
  localparam int KBD_PIN_BIT = 7;
  localparam int EN_RX = 0;
  localparam int EN_TXE = 1;
  localparam int EN_TXC = 2;
  localparam int EN_IDLE = 3;
  localparam int EN_SPI = 4;
  localparam int EN_ACCE = 5;
  localparam int EN_ACCO = 6;
  localparam int EN_TOF = 7;
  localparam int EN_RTI = 0;
  localparam int EN_HS = 1;
  localparam int EN_IRQ = 2;
  localparam int WDOG_LOG2_STEP = 2;
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_CLKFAIL = 16'hfffc;
  localparam logic [15:0] VEC_WDOG = 16'hfffa;
  localparam logic [15:0] VEC_ILLEGAL = 16'hfff8;
  localparam logic [15:0] VEC_SWI = 16'hfff6;
  localparam logic [15:0] VEC_NONMASKABLE_PIN_REQUEST = 16'hfff4;
  // Maskable vector groups, listed from highest to lowest default priority.
  localparam int NUM_GROUPS = 15;
  localparam logic [3:0] GRP_IRQ = 4'h0;
  localparam logic [3:0] GRP_RTI = 4'h1;
  localparam logic [3:0] GRP_IC1 = 4'h2;
  localparam logic [3:0] GRP_CH4 = 4'h9;
  localparam logic [3:0] GRP_TOF = 4'ha;
  localparam logic [3:0] GRP_ACCO = 4'hb;
  localparam logic [3:0] GRP_ACCE = 4'hc;
  localparam logic [3:0] GRP_SPI = 4'hd;
  localparam logic [3:0] GRP_SCI = 4'he;
  localparam logic [15:0] VEC_GRP_TOP = 16'hfff2;
  localparam logic [15:0] VEC_GRP_STEP = 16'h0002;

  function automatic logic [15:0] group_vector(input logic [3:0] g);
    group_vector = VEC_GRP_TOP - VEC_GRP_STEP * {12'h000, g};
  endfunction

  function automatic logic [3:0] psel_to_group(input logic [3:0] p);
    case (p)
      4'h0: psel_to_group = GRP_TOF;
      4'h1: psel_to_group = GRP_ACCO;
      4'h2: psel_to_group = GRP_ACCE;
      4'h3: psel_to_group = GRP_SPI;
      4'h4: psel_to_group = GRP_SCI;
      4'h5: psel_to_group = GRP_IRQ;
      4'h6: psel_to_group = GRP_IRQ;
      4'h7: psel_to_group = GRP_RTI;
      default: psel_to_group = p - 4'h6;
    endcase
  endfunction
endpackage

// ---- design/rip_sync.sv ----
// Two-stage synchroniser for asynchronous level inputs.
`timescale 1ns/1ps
module rip_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule

// ---- verification/rip_cpu_model.sv ----
// Behavioural CPU core that owns the mask bits, raises traps and records the vectors it takes.
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Core model
//----------------------------------------------------------------------
module rip_cpu_model (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic i_mask_req_i,
  input wire logic x_mask_req_i,
  input wire logic swi_req_i,
  input wire logic ill_req_i,
  input wire logic irq_req_i,
  input wire logic [15:0] irq_vec_i,
  input wire logic trap_vld_i,
  input wire logic [15:0] trap_vec_i,
  output logic i_mask_o,
  output logic x_mask_o,
  output logic swi_o,
  output logic illegal_o,
  output logic [15:0] taken_vec_o,
  output logic [15:0] trap_seen_o
);
  // Both masks come out of reset set, as a real core would, so nothing is taken early.
  // Software moves the mask only on request, so a promotion write can be bracketed by it.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      i_mask_o <= 1'b1;
      x_mask_o <= 1'b1;
      swi_o <= 1'b0;
      illegal_o <= 1'b0;
    end else begin
      i_mask_o <= i_mask_req_i;
      x_mask_o <= x_mask_req_i;
      swi_o <= swi_req_i;
      illegal_o <= ill_req_i;
    end
  end

  // The vector is only taken while the core is willing to accept it.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      taken_vec_o <= 16'h0000;
      trap_seen_o <= 16'h0000;
    end else begin
      if (irq_req_i && !i_mask_o) begin
        taken_vec_o <= irq_vec_i;
      end
      if (trap_vld_i) begin
        trap_seen_o <= trap_vec_i;
      end
    end
  end
endmodule

// ---- verification/rip_top_tb.sv ----
// Self-checking testbench of the reset and interrupt prioritiser.
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Bench
//----------------------------------------------------------------------
module rip_top_tb import rip_pkg::*;;
  logic clk, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, im_req = 1'b1, xm_req = 1'b1, swi_req = 1'b0, ill_req = 1'b0;
  logic smode = 1'b0, wdis = 1'b1, irq_n = 1'b1, nonmaskable_pin_request_n = 1'b1, slow = 1'b0, ovr = 1'b0, rti = 1'b0;
  logic hs = 1'b0, wsvc = 1'b0, stx = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00, pf = 8'h00, tch = 8'h00, rdata, opts;
  logic [6:0] kbd_n = 7'h7f;
  logic imask, xmask, swi, ill, irq_req, trap_vld, rst_req, clk_rdy;
  logic [15:0] irq_vec, trap_vec, rst_vec, taken, tseen;
  int miscompares = 0;
  int n_tests = 0;

  rip_top #(.WDOG_BASE_LOG2(3), .E_DIV(2), .STOP_DELAY_CYC(4)) rip_top_inst (
    .sys_clk_i(clk), .arst_n_i(rst_n), .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .i_mask_i(imask), .x_mask_i(xmask), .special_mode_i(smode), .watchdog_disable_i(wdis),
    .irq_pin_n_i(irq_n), .nonmaskable_pin_request_pin_n_i(nonmaskable_pin_request_n), .kbd_line_n_i(kbd_n), .clock_slow_i(slow),
    .sci_rx_full_i(pf[0]), .sci_overrun_i(ovr), .sci_tx_empty_i(pf[1]), .sci_tx_done_i(pf[2]),
    .sci_idle_i(pf[3]), .spi_done_i(pf[4]), .acc_edge_i(pf[5]), .acc_ovf_i(pf[6]), .timer_ovf_i(pf[7]),
    .timer_chan_i(tch), .rti_i(rti), .handshake_i(hs), .swi_i(swi), .illegal_i(ill),
    .wdog_service_i(wsvc), .stop_exit_i(stx), .irq_req_o(irq_req), .irq_vec_o(irq_vec),
    .trap_vld_o(trap_vld), .trap_vec_o(trap_vec), .reset_req_o(rst_req), .reset_vec_o(rst_vec),
    .clock_ready_o(clk_rdy), .options_o(opts));

  rip_cpu_model rip_cpu_model_inst (
    .sys_clk_i(clk), .arst_n_i(rst_n), .i_mask_req_i(im_req), .x_mask_req_i(xm_req), .swi_req_i(swi_req),
    .ill_req_i(ill_req), .irq_req_i(irq_req), .irq_vec_i(irq_vec), .trap_vld_i(trap_vld),
    .trap_vec_i(trap_vec), .i_mask_o(imask), .x_mask_o(xmask), .swi_o(swi), .illegal_o(ill),
    .taken_vec_o(taken), .trap_seen_o(tseen));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is taken just after that edge.
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk({8'h00, rdata}, {8'h00, e});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #40000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rchk(ADDR_OPTIONS, OPTIONS_RST);
    rchk(ADDR_PROMOTE, {4'h0, PROMOTE_RST});
    wreg(ADDR_OPTIONS, 8'h30);
    wreg(ADDR_OPTIONS, 8'h03);
    rchk(ADDR_OPTIONS, 8'h30);
    chk({8'h00, opts}, 16'h0030);
    rchk(8'h00, 8'h00);
    done("options");
    @(posedge clk) im_req <= 1'b0;
    wreg(ADDR_EN_SERIAL, 8'hff);
    wreg(ADDR_EN_TIMER, 8'hff);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk) pf <= 8'h01 << k;
      cyc(2);
      #1 chk(irq_vec, (k < 4) ? 16'hffd6 : 16'hffd8 + 16'(2 * (k - 4)));
    end
    @(posedge clk) pf <= 8'h00;
    @(posedge clk) ovr <= 1'b1;
    cyc(2);
    #1 chk(irq_vec, 16'hffd6);
    @(posedge clk) ovr <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk) tch <= 8'h01 << k;
      cyc(2);
      #1 chk(irq_vec, 16'hffee - 16'(2 * k));
    end
    @(posedge clk) tch <= 8'h00;
    wreg(ADDR_EN_MISC, 8'h05);
    @(posedge clk) rti <= 1'b1;
    cyc(2);
    #1 chk(irq_vec, 16'hfff0);
    @(posedge clk) pf <= 8'h80;
    cyc(2);
    #1 chk(irq_vec, 16'hfff0);
    done("vectors");
    @(posedge clk) im_req <= 1'b1;
    cyc(3);
    #1 chk({15'h0000, irq_req}, 16'h0000);
    wreg(ADDR_PROMOTE, 8'h00);
    rchk(ADDR_PROMOTE, 8'h00);
    @(posedge clk) im_req <= 1'b0;
    cyc(3);
    #1 chk(irq_vec, 16'hffde);
    wreg(ADDR_PROMOTE, 8'h07);
    rchk(ADDR_PROMOTE, 8'h00);
    @(posedge clk) xm_req <= 1'b0;
    @(posedge clk) nonmaskable_pin_request_n <= 1'b0;
    cyc(5);
    #1 chk(irq_vec, VEC_NONMASKABLE_PIN_REQUEST);
    @(posedge clk) nonmaskable_pin_request_n <= 1'b1;
    wreg(ADDR_EN_SERIAL, 8'h7f);
    @(posedge clk) rti <= 1'b0;
    cyc(5);
    #1 chk({15'h0000, irq_req}, 16'h0000);
    done("priority");
    @(posedge clk) irq_n <= 1'b0;
    cyc(5);
    rchk(ADDR_KBD_STAT, 8'h80);
    rchk(ADDR_KBD_STAT, 8'h00);
    cyc(2);
    #1 chk({15'h0000, irq_req}, 16'h0000);
    @(posedge clk) irq_n <= 1'b1;
    wreg(ADDR_KBD_EN, 8'h01);
    @(posedge clk) kbd_n <= 7'h7e;
    cyc(5);
    #1 chk(irq_vec, 16'hfff2);
    chk(taken, 16'hfff2);
    @(posedge clk) kbd_n <= 7'h7f;
    cyc(2);
    rchk(ADDR_KBD_STAT, 8'h01);
    rchk(ADDR_KBD_STAT, 8'h00);
    wreg(ADDR_KBD_STAT, 8'hff);
    rchk(ADDR_KBD_STAT, 8'h00);
    done("keyboard");
    for (int j = 0; j < 2; j++) begin
      @(posedge clk) {swi_req, ill_req} <= (j == 0) ? 2'b10 : 2'b01;
      @(posedge clk) {swi_req, ill_req} <= 2'b00;
      cyc(3);
      #1 chk(tseen, (j == 0) ? VEC_SWI : VEC_ILLEGAL);
    end
    @(posedge clk) stx <= 1'b1;
    @(posedge clk) stx <= 1'b0;
    cyc(1);
    #1 chk({15'h0000, clk_rdy}, 16'h0000);
    cyc(6);
    #1 chk({15'h0000, clk_rdy}, 16'h0001);
    done("traps and stop");
    chk({15'h0000, rst_req}, 16'h0000);
    @(posedge clk) begin
      wsvc <= 1'b1;
      wdis <= 1'b0;
    end
    @(posedge clk) wsvc <= 1'b0;
    cyc(8);
    #1 chk({15'h0000, rst_req}, 16'h0000);
    cyc(16);
    #1 chk(rst_vec, VEC_WDOG);
    @(posedge clk) slow <= 1'b1;
    cyc(5);
    #1 chk(rst_vec, VEC_WDOG);
    wreg(ADDR_OPTIONS, 8'h38);
    cyc(3);
    #1 chk(rst_vec, VEC_CLKFAIL);
    @(posedge clk) rst_n <= 1'b0;
    slow <= 1'b0;
    wdis <= 1'b1;
    cyc(3);
    rst_n <= 1'b1;
    #1 chk(rst_vec, VEC_RESET);
    chk({15'h0000, rst_req}, 16'h0000);
    rchk(ADDR_OPTIONS, OPTIONS_RST);
    @(posedge clk) irq_n <= 1'b0;
    wreg(ADDR_EN_MISC, 8'h04);
    cyc(5);
    #1 chk(irq_vec, 16'hfff2);
    rchk(ADDR_KBD_STAT, 8'h80);
    cyc(2);
    #1 chk({15'h0000, irq_req}, 16'h0001);
    @(posedge clk) smode <= 1'b1;
    wreg(ADDR_OPTIONS, 8'h23);
    wreg(ADDR_OPTIONS, 8'h20);
    rchk(ADDR_OPTIONS, 8'h20);
    chk({8'h00, opts}, 16'h0020);
    done("resets");
    report_and_stop();
  end
endmodule
